/* File: rtl/svmon_params.svh */
`ifndef SVMON_PARAMS_SVH
`define SVMON_PARAMS_SVH
`define SVMON_THR_W        3
`define SVMON_EVT_LINE     8
`define SVMON_THR_RESET    3'h0
`define SVMON_EN_RESET     1'b0
`define SVMON_RST_HOLD     8'h10
`endif

/* File: rtl/svmon_pkg.sv */
package svmon_pkg;
  typedef struct packed {
    logic [2:0] threshold_select;
    logic       detector_enable;
  } svmon_ctrl_s;
  typedef struct packed {
    logic rise_en;
    logic fall_en;
    logic line_en;
  } svmon_evt_cfg_s;
  typedef enum logic [1:0] {
    SVMON_RST_ACTIVE = 2'b00,
    SVMON_RST_HOLD   = 2'b01,
    SVMON_RST_RUN    = 2'b10
  } svmon_rst_e;
endpackage

/* File: rtl/svmon_top.sv */
`timescale 1ns/100ps
`include "svmon_params.svh"
module svmon_top (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire svmon_pkg::svmon_ctrl_s        power_control_reg,
  input  wire svmon_pkg::svmon_evt_cfg_s     evt_cfg,
  input  wire logic                          cmp_below,
  input  wire logic                          por_ok,
  input  wire logic                          pdr_ok,
  output logic [`SVMON_THR_W-1:0]            cmp_threshold,
  output logic                               cmp_enable,
  output logic                               power_status_reg,
  output logic                               evt_line_8,
  output logic                               detector_irq,
  output logic                               sys_rst_n
);
  // Reset release path
  logic                  rst_s1_reg;
  logic                  rst_s1_next;
  logic                  rst_s2_reg;
  logic                  rst_s2_next;

  // Pin synchronisers
  logic [2:0]            pin_raw;
  wire  logic [2:0]      pin_sync;
  logic                  cmp_sync;
  logic                  por_sync;
  logic                  pdr_sync;

  // Configuration copy
  logic [2:0]            thr_reg;
  logic [2:0]            thr_next;
  logic                  en_reg;
  logic                  en_next;

  // Detector and event line
  logic                  flag_reg;
  logic                  flag_next;
  logic                  cmp_d_reg;
  logic                  cmp_d_next;
  logic                  line_reg;
  logic                  line_next;
  logic                  irq_reg;
  logic                  irq_next;
  logic                  rise;
  logic                  fall;
  logic                  rise_hit;
  logic                  fall_hit;

  // System reset sequencer
  svmon_pkg::svmon_rst_e st_reg;
  svmon_pkg::svmon_rst_e st_next;
  logic [7:0]            hold_reg;
  logic [7:0]            hold_next;
  logic                  hold_done;
  logic                  srst_reg;
  logic                  srst_next;
  logic                  supply_ok;

  always_comb begin
    rst_s1_next = 1'h1;
    rst_s2_next = rst_s1_reg;
  end

  // Release is synchronous, assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'h0;
      rst_s2_reg <= 1'h0;
    end else begin
      rst_s1_reg <= rst_s1_next;
      rst_s2_reg <= rst_s2_next;
    end
  end

  // Analog inputs are asynchronous; two stages before any use
  // Comparator is bit 0, the two detectors above it
  assign pin_raw = {pdr_ok, por_ok, cmp_below};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic s1_reg;
    logic s1_next;
    logic s2_reg;
    logic s2_next;

    always_comb begin
      s1_next = pin_raw[i];
      s2_next = s1_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
        s1_reg <= 1'h0;
        s2_reg <= 1'h0;
      end else begin
        s1_reg <= s1_next;
        s2_reg <= s2_next;
      end
    end

    assign pin_sync[i] = s2_reg;
  end

  assign cmp_sync  = pin_sync[0];
  assign por_sync  = pin_sync[1];
  assign pdr_sync  = pin_sync[2];
  // Both detectors must agree the supply is up
  assign supply_ok = por_sync & pdr_sync;

  // Copied every clock; no write strobe needed
  always_comb begin
    thr_next = power_control_reg.threshold_select;
    en_next  = power_control_reg.detector_enable;
  end

  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      thr_reg <= `SVMON_THR_RESET;
      en_reg  <= `SVMON_EN_RESET;
    end else begin
      thr_reg <= thr_next;
      en_reg  <= en_next;
    end
  end

  // Edge seen on the synchronised copy only
  assign rise     = flag_reg & ~cmp_d_reg;
  assign fall     = ~flag_reg & cmp_d_reg;
  // Supply falling below threshold is a rising line edge
  assign rise_hit = evt_cfg.rise_en & rise;
  assign fall_hit = evt_cfg.fall_en & fall;

  always_comb begin
    // Disabled detector reads as not below; disabling while below gives one falling edge
    flag_next  = en_reg & cmp_sync;
    cmp_d_next = flag_reg;
    line_next  = flag_reg;
    irq_next   = evt_cfg.line_en & (rise_hit | fall_hit);
  end

  // Limitation: a crossing shorter than a clock may be missed
  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      flag_reg  <= 1'h0;
      cmp_d_reg <= 1'h0;
      line_reg  <= 1'h0;
      irq_reg   <= 1'h0;
    end else begin
      flag_reg  <= flag_next;
      cmp_d_reg <= cmp_d_next;
      line_reg  <= line_next;
      irq_reg   <= irq_next;
    end
  end

  // Reset stretch keeps system down through supply chatter
  assign hold_done = (hold_reg == 8'h01);

  always_comb begin
    st_next   = st_reg;
    hold_next = hold_reg;
    srst_next = 1'h0;
    case (st_reg)
      svmon_pkg::SVMON_RST_ACTIVE: begin
        hold_next = `SVMON_RST_HOLD;
        if (supply_ok) begin
          st_next = svmon_pkg::SVMON_RST_HOLD;
        end
      end

      svmon_pkg::SVMON_RST_HOLD: begin
        hold_next = hold_reg - 8'h01;
        if (!supply_ok) begin
          st_next = svmon_pkg::SVMON_RST_ACTIVE;
        end else if (hold_done) begin
          st_next = svmon_pkg::SVMON_RST_RUN;
        end
      end

      svmon_pkg::SVMON_RST_RUN: begin
        srst_next = 1'h1;
        if (!supply_ok) begin
          // Drop at once; no stretch on the way down
          st_next   = svmon_pkg::SVMON_RST_ACTIVE;
          srst_next = 1'h0;
        end
      end

      default: begin
        st_next = svmon_pkg::SVMON_RST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      st_reg   <= svmon_pkg::SVMON_RST_ACTIVE;
      hold_reg <= 8'h00;
      srst_reg <= 1'h0;
    end else begin
      st_reg   <= st_next;
      hold_reg <= hold_next;
      srst_reg <= srst_next;
    end
  end

  // Every output comes straight from a flop
  assign cmp_threshold    = thr_reg;
  assign cmp_enable       = en_reg;
  assign power_status_reg = flag_reg;
  assign evt_line_8       = line_reg;
  assign detector_irq     = irq_reg;
  assign sys_rst_n        = srst_reg;
endmodule

/* File: tb/svmon_sva.sv */
`timescale 1ns/100ps
module svmon_sva (
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire logic                      cmp_below,
  input wire logic                      por_ok,
  input wire logic                      pdr_ok,
  input wire logic                      cmp_enable,
  input wire logic                      power_status_reg,
  input wire logic                      evt_line_8,
  input wire logic                      detector_irq,
  input wire logic                      sys_rst_n,
  input wire logic [2:0]                cmp_threshold,
  input wire svmon_pkg::svmon_ctrl_s    power_control_reg,
  input wire svmon_pkg::svmon_evt_cfg_s evt_cfg
);
  logic [2:0] up_reg;
  // Skip the reset pipeline so stale past values never fire
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) up_reg <= 3'h0;
    else if (!up_reg[2]) up_reg <= up_reg + 3'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!up_reg[2]);
  a_thr_follow: assert property (
    ##1 cmp_threshold == $past(power_control_reg.threshold_select))
    else $error("threshold not copied");
  a_line_follow: assert property (
    ##1 evt_line_8 == $past(power_status_reg)) else $error("line lag");
  a_irq_match: assert property (
    detector_irq == ($past(evt_cfg.line_en) &&
    ($past(evt_cfg.rise_en) && $rose(evt_line_8) ||
    $past(evt_cfg.fall_en) && $fell(evt_line_8)))) else $error("irq");
  a_flag_off: assert property (
    !cmp_enable [*2] |-> !power_status_reg) else $error("flag on");
  a_flag_track: assert property (
    (cmp_enable && $stable(cmp_below)) [*4] |-> power_status_reg == cmp_below)
    else $error("flag wrong");
  a_sync_delay: assert property (
    (cmp_enable && $stable(cmp_below)) [*3] ##1 $rose(cmp_below) |=>
    $stable(power_status_reg)) else $error("flag too fast");
  a_por_rst: assert property (
    !(por_ok && pdr_ok) |-> ##[1:4] !sys_rst_n) else $error("no reset");
  cover property (detector_irq);
  cover property ($rose(sys_rst_n));
  cover property ($fell(power_status_reg) && !cmp_enable);
endmodule
bind svmon_top svmon_sva u_sva (.*);

/* File: tb/svmon_evt_model.sv */
`timescale 1ns/100ps
module svmon_evt_model (
  input wire logic clk_sys,
  input wire logic detector_irq,
  output logic [7:0] irq_count
);
  initial irq_count = 8'h0;
  // Running total, never cleared; one pulse is one event
  always @(posedge clk_sys) if (detector_irq) irq_count <= irq_count + 8'h1;
endmodule

/* File: tb/svmon_top_test.sv */
`timescale 1ns/100ps
module svmon_top_test;
  logic clk_sys = 1'b0, rst_n = 1'b0, cmp_below = 1'b0;
  logic por_ok = 1'b1, pdr_ok = 1'b1, cmp_enable, power_status_reg;
  logic evt_line_8, detector_irq, sys_rst_n;
  logic [2:0] cmp_threshold;
  logic [7:0] irq_count, exp_irq = 8'h0;
  svmon_pkg::svmon_ctrl_s power_control_reg = 4'h0;
  svmon_pkg::svmon_evt_cfg_s evt_cfg = 3'h0;
  int num_errors = 0, check_count = 0, cycles = 0;
  svmon_top DUT (.*);
  svmon_evt_model u_model (.clk_sys, .detector_irq, .irq_count);
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cycles == 1000) begin
    num_errors++;
    give_verdict();
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_select;
    for (int i = 0; i < 8; i++) begin
      power_control_reg.threshold_select = 3'(i);
      tick(1);
      chk("thr", cmp_threshold, 8'(i));
    end
  endtask
  task automatic t_edges;
    power_control_reg.detector_enable = 1'b1;
    for (int c = 0; c < 8; c++) begin
      evt_cfg = 3'(c);
      tick(2);
      chk("en", cmp_enable, 8'h1);
      cmp_below = 1'b1;
      tick(6);
      chk("flag", power_status_reg, 8'h1);
      chk("line", evt_line_8, 8'h1);
      cmp_below = 1'b0;
      tick(6);
      exp_irq += c[0] ? (8'(c[2]) + 8'(c[1])) : 8'h0;
      chk("irqs", irq_count, exp_irq);
    end
  endtask
  task automatic t_off;
    evt_cfg = 3'h0;
    cmp_below = 1'b1;
    tick(6);
    power_control_reg.detector_enable = 1'b0;
    tick(3);
    chk("off", power_status_reg, 8'h0);
    chk("en off", cmp_enable, 8'h0);
    cmp_below = 1'b0;
  endtask
  task automatic t_power;
    por_ok = 1'b0;
    tick(5);
    chk("por", sys_rst_n, 8'h0);
    por_ok = 1'b1;
    tick(25);
    chk("run", sys_rst_n, 8'h1);
    pdr_ok = 1'b0;
    tick(5);
    chk("pdr", sys_rst_n, 8'h0);
    pdr_ok = 1'b1;
  endtask
  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(30);
    t_select;
    t_edges;
    t_off;
    t_power;
    give_verdict();
  end
endmodule
